// file: hdl/prs_pkg.sv
// Purpose: constants shared by the reset / status output block
// Assumes: 40 MHz system clock, APB with 32-bit data
// Notes:   all times are in microseconds; cycle counts are derived
package prs_pkg;
    // ==========================================================
    // clock and timebase
    localparam int unsigned CLK_FREQ_HZ  = 40_000_000;
    localparam int unsigned HZ_PER_MHZ   = 1_000_000;
    localparam int unsigned CYC_PER_US   = CLK_FREQ_HZ / HZ_PER_MHZ;
    localparam int unsigned NUM_RAILS    = 7;
    localparam int unsigned NUM_BUCKS    = 4;
    localparam int unsigned DLY_W        = 12;
    localparam int unsigned SS_W         = 11;

    // ==========================================================
    // release delays: base + step * code, in us
    localparam logic [DLY_W-1:0] AUXA_BASE_US = 12'd400;
    localparam logic [DLY_W-1:0] AUXA_STEP_US = 12'd227;
    localparam logic [DLY_W-1:0] AUXB_BASE_US = 12'd200;
    localparam logic [DLY_W-1:0] AUXB_STEP_US = 12'd114;
    localparam logic [DLY_W-1:0] MAIN_BASE_US = 12'd200;
    localparam logic [DLY_W-1:0] MAIN_STEP_US = 12'd114;

    // ==========================================================
    // softstart tables in us, entry index is the 3-bit code
    localparam logic [7:0][SS_W-1:0] SS_BUCK_US = {11'd485, 11'd440, 11'd395, 11'd350,
                                                   11'd300, 11'd250, 11'd200, 11'd150};
    localparam logic [7:0][SS_W-1:0] SS_B4_US   = {11'd204, 11'd178, 11'd153, 11'd127,
                                                   11'd102, 11'd76, 11'd51, 11'd25};
    localparam logic [SS_W-1:0] SS_SCALE_NUM = 11'd3;
    localparam logic [SS_W-1:0] SS_SCALE_RND = 11'd3;
    localparam int unsigned     SS_SCALE_SH  = 2;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BUCK   = 8'h04;
    localparam logic [7:0] OFS_SSRAMP = 8'h08;
    localparam logic [7:0] OFS_UVMASK = 8'h0c;
    localparam logic [7:0] OFS_AUXSRC = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // CTRL fields
    localparam int unsigned CTRL_AUXA_DLY = 0;
    localparam int unsigned CTRL_AUXB_DLY = 4;
    localparam int unsigned CTRL_MAIN_DLY = 8;
    localparam int unsigned CTRL_EXT_POL  = 12;
    localparam int unsigned CTRL_PG_SRC   = 16;
    localparam int unsigned CTRL_AUXA_CFG = 20;
    localparam int unsigned CTRL_AUXB_CFG = 22;
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK     = 32'h00f7_1777;
    // BUCK fields, one bit per buck at these bases
    localparam int unsigned BUCK_DISABLE  = 0;
    localparam int unsigned BUCK_LP_DIS   = 4;
    localparam int unsigned BUCK_LP_SEL   = 8;
    localparam int unsigned BUCK_DISCHG   = 12;
    localparam int unsigned BUCK_REF06    = 16;
    localparam logic [31:0] BUCK_RST      = 32'h0000_0000;
    localparam logic [31:0] BUCK_MASK     = 32'h000f_ffff;
    // SSRAMP: 3-bit code per buck, 4-bit pitch
    localparam int unsigned SS_PITCH      = 4;
    localparam logic [31:0] SSRAMP_RST    = 32'h0000_0000;
    localparam logic [31:0] SSRAMP_MASK   = 32'h0000_7777;
    localparam logic [31:0] UVMASK_RST    = 32'h0000_0000;
    localparam logic [31:0] UVMASK_MASK   = 32'h0000_007f;
    // AUXSRC: rail select for channel a at 0, channel b at 8
    localparam int unsigned AUXSRC_B      = 8;
    localparam logic [31:0] AUXSRC_RST    = 32'h0000_7f7f;
    localparam logic [31:0] AUXSRC_MASK   = 32'h0000_7f7f;
    // STATUS fields
    localparam int unsigned ST_RAIL_EN    = 0;
    localparam int unsigned ST_MAIN_RST   = 8;
    localparam int unsigned ST_AUXA_RST   = 9;
    localparam int unsigned ST_AUXB_RST   = 10;
    localparam int unsigned ST_PG_LOW     = 11;
    localparam int unsigned ST_EXTERNAL_ENABLE_OUT     = 12;
    localparam int unsigned ST_STRAP      = 13;
    localparam int unsigned ST_ACTIVE     = 14;
    localparam int unsigned ST_SS_BUSY    = 16;

    // ==========================================================
    // aux pin configuration and power-good source codes
    typedef enum logic [1:0] {
        AUX_POK    = 2'h0,
        AUX_SLEEP  = 2'h1,
        AUX_WINDOW = 2'h2,
        AUX_INPUT  = 2'h3
    } prs_aux_cfg_t;

    localparam logic [2:0] PG_LDO2_B4 = 3'h5;
    localparam logic [2:0] PG_LDO3_B4 = 3'h7;
    localparam int unsigned RAIL_B4   = 3;
    localparam int unsigned RAIL_LDO2 = 5;
    localparam int unsigned RAIL_LDO3 = 6;

    // default power-up order: rail index per step
    localparam logic [NUM_RAILS-1:0][2:0] SEQ_ORDER_DFLT = {3'h6, 3'h5, 3'h4, 3'h3,
                                                            3'h2, 3'h1, 3'h0};
endpackage : prs_pkg

// file: hdl/prs_reset_status.sv
// Purpose: reset, enable and power-good output control of a multi-rail manager
// Assumes: inputs synchronous to clk_sys; analog comparators give rail ok levels
// Notes:   rails 0..3 are bucks, 4..6 are LDOs; open-drain pins drive low only
`timescale 1ns/1ps
module prs_reset_status #(
    parameter int unsigned                               TICK_CYCLES = prs_pkg::CYC_PER_US,
    parameter logic [prs_pkg::NUM_RAILS-1:0][2:0]        SEQ_ORDER   = prs_pkg::SEQ_ORDER_DFLT
) (
    input  wire logic                                    clk_sys,
    input  wire logic                                    srst,
    // apb slave
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [7:0]                              paddr,
    input  wire logic [31:0]                             pwdata,
    output logic      [31:0]                             prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    // analog side status
    input  wire logic                                    vinUvloOk,
    input  wire logic                                    vinWindowOk,
    input  wire logic [prs_pkg::NUM_RAILS-1:0]           railPowerOk,
    input  wire logic                                    sleepState,
    input  wire logic                                    faultRestart,
    input  wire logic                                    modeStrap,
    // rail control
    output logic      [prs_pkg::NUM_RAILS-1:0]           railEnable,
    output logic      [prs_pkg::NUM_BUCKS-1:0]           lightLoadLowPowerMode,
    output logic      [prs_pkg::NUM_BUCKS-1:0]           outputDischargeOn,
    output logic      [prs_pkg::NUM_BUCKS-1:0]           softstartBusy,
    // pins
    output logic                                         mainResetOut,
    output logic                                         mainResetOe,
    input  wire logic                                    auxResetInA,
    output logic                                         auxResetOutA,
    output logic                                         auxResetOeA,
    input  wire logic                                    auxResetInB,
    output logic                                         auxResetOutB,
    output logic                                         auxResetOeB,
    output logic                                         externalEnableOut,
    output logic                                         powerGoodOut,
    output logic                                         powerGoodOe
);
    import prs_pkg::*;

    if (TICK_CYCLES < 1) begin : g_chk_tick
        $error("TICK_CYCLES must be at least 1");
    end

    // ==========================================================
    // microsecond timebase
    logic [15:0] tickCnt_q;
    logic        usTick;
    assign usTick = (tickCnt_q == 16'(TICK_CYCLES - 1));
    always_ff @(posedge clk_sys) begin
        if (srst || usTick) tickCnt_q <= '0;
        else                tickCnt_q <= tickCnt_q + 16'h0001;
    end

    // ==========================================================
    // register file
    logic [31:0] ctrl_q, buck_q, ssramp_q, uvmask_q, auxsrc_q;
    logic [31:0] statusWord, rdMux;
    logic        hit, apbSetup, apbDone, wrDone;
    logic        selCtrl, selBuck, selSs, selUv, selAux, selSt;

    assign selCtrl  = (paddr == OFS_CTRL);
    assign selBuck  = (paddr == OFS_BUCK);
    assign selSs    = (paddr == OFS_SSRAMP);
    assign selUv    = (paddr == OFS_UVMASK);
    assign selAux   = (paddr == OFS_AUXSRC);
    assign selSt    = (paddr == OFS_STATUS);
    assign hit      = selCtrl | selBuck | selSs | selUv | selAux | selSt;
    // first access cycle latches read data; the next one completes
    assign apbSetup = psel & penable & ~pready;
    assign apbDone  = psel & penable & pready;
    assign wrDone   = apbDone & pwrite;
    assign rdMux    = selCtrl ? ctrl_q   :
                      selBuck ? buck_q   :
                      selSs   ? ssramp_q :
                      selUv   ? uvmask_q :
                      selAux  ? auxsrc_q :
                      selSt   ? statusWord : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apbSetup;
            pslverr <= apbSetup & ~hit;
            if (apbSetup) prdata <= pwrite ? 32'h0000_0000 : rdMux;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_q   <= CTRL_RST;
            buck_q   <= BUCK_RST;
            ssramp_q <= SSRAMP_RST;
            uvmask_q <= UVMASK_RST;
            auxsrc_q <= AUXSRC_RST;
        end else if (wrDone) begin
            if (selCtrl) ctrl_q   <= pwdata & CTRL_MASK;
            if (selBuck) buck_q   <= pwdata & BUCK_MASK;
            if (selSs)   ssramp_q <= pwdata & SSRAMP_MASK;
            if (selUv)   uvmask_q <= pwdata & UVMASK_MASK;
            if (selAux)  auxsrc_q <= pwdata & AUXSRC_MASK;
        end
    end

    // field views
    logic [2:0]           pgSrc;
    logic                 extPol;
    prs_aux_cfg_t         auxCfgA, auxCfgB;
    logic [NUM_RAILS-1:0] auxSelA, auxSelB, uvMask;
    logic [NUM_BUCKS-1:0] bkDisable, lpDis, lpSel, dischEn, ref06;
    assign pgSrc     = ctrl_q[CTRL_PG_SRC +: 3];
    assign extPol    = ctrl_q[CTRL_EXT_POL];
    assign auxCfgA   = prs_aux_cfg_t'(ctrl_q[CTRL_AUXA_CFG +: 2]);
    assign auxCfgB   = prs_aux_cfg_t'(ctrl_q[CTRL_AUXB_CFG +: 2]);
    assign auxSelA   = auxsrc_q[0 +: NUM_RAILS];
    assign auxSelB   = auxsrc_q[AUXSRC_B +: NUM_RAILS];
    assign uvMask    = uvmask_q[0 +: NUM_RAILS];
    assign bkDisable = buck_q[BUCK_DISABLE +: NUM_BUCKS];
    assign lpDis     = buck_q[BUCK_LP_DIS +: NUM_BUCKS];
    assign lpSel     = buck_q[BUCK_LP_SEL +: NUM_BUCKS];
    assign dischEn   = buck_q[BUCK_DISCHG +: NUM_BUCKS];
    assign ref06     = buck_q[BUCK_REF06 +: NUM_BUCKS];

    // ==========================================================
    // mode strap: sampled on the uvlo rising crossing only
    logic uvloOkPrev_q, strap_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            uvloOkPrev_q <= 1'b0;
            strap_q      <= 1'b0;
        end else begin
            uvloOkPrev_q <= vinUvloOk;
            if (vinUvloOk && !uvloOkPrev_q) strap_q <= modeStrap;
        end
    end

    // ==========================================================
    // power-up sequencer
    typedef enum logic [1:0] {SEQ_OFF, SEQ_STEP, SEQ_WAIT, SEQ_ACTIVE} prs_seq_t;
    prs_seq_t             seqState_q;
    logic [2:0]           seqIdx_q, seqRail;
    logic [NUM_RAILS-1:0] seqOn_q, auxGate, railEn_d;
    logic                 active;
    assign seqRail = SEQ_ORDER[seqIdx_q];
    assign active  = (seqState_q == SEQ_ACTIVE);

    always_ff @(posedge clk_sys) begin
        if (srst || !vinUvloOk) begin
            seqState_q <= SEQ_OFF;
            seqIdx_q   <= '0;
            seqOn_q    <= '0;
        end else begin
            case (seqState_q)
                SEQ_OFF: begin
                    seqIdx_q   <= '0;
                    seqState_q <= SEQ_STEP;
                end
                SEQ_STEP: begin
                    seqOn_q[seqRail] <= 1'b1;
                    seqState_q       <= SEQ_WAIT;
                end
                SEQ_WAIT: begin
                    if (railPowerOk[seqRail]) begin
                        if (seqIdx_q == 3'(NUM_RAILS - 1)) begin
                            seqState_q <= SEQ_ACTIVE;
                        end else begin
                            seqIdx_q   <= seqIdx_q + 3'h1;
                            seqState_q <= SEQ_STEP;
                        end
                    end
                end
                SEQ_ACTIVE: seqState_q <= SEQ_ACTIVE;
                default:    seqState_q <= SEQ_OFF;
            endcase
        end
    end

    // an aux pin set as input holds its selected rails off while low
    assign auxGate = ((auxCfgA == AUX_INPUT && !auxResetInA) ? auxSelA : '0) |
                     ((auxCfgB == AUX_INPUT && !auxResetInB) ? auxSelB : '0);
    // register disables only bite once the start sequence is done
    assign railEn_d = seqOn_q & ~auxGate &
                      ~(active ? {{(NUM_RAILS-NUM_BUCKS){1'b0}}, bkDisable} : '0);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            railEnable            <= '0;
            lightLoadLowPowerMode <= '0;
            outputDischargeOn     <= '0;
        end else begin
            railEnable            <= railEn_d;
            lightLoadLowPowerMode <= ~lpDis & lpSel;
            outputDischargeOn     <= ~railEn_d[NUM_BUCKS-1:0] & dischEn;
        end
    end

    // ==========================================================
    // softstart timers, one per buck
    for (genvar b = 0; b < NUM_BUCKS; b++) begin : g_ss
        logic [2:0]      code;
        logic [SS_W-1:0] tab, scaled, cnt_q;
        logic            start;
        assign code   = ssramp_q[b*SS_PITCH +: 3];
        assign tab    = (b == RAIL_B4) ? SS_B4_US[code] : SS_BUCK_US[code];
        assign scaled = ref06[b] ? SS_W'((tab * SS_SCALE_NUM + SS_SCALE_RND) >> SS_SCALE_SH)
                                 : tab;
        assign start  = (railEn_d[b] & ~railEnable[b]) | (faultRestart & railEn_d[b]);
        always_ff @(posedge clk_sys) begin
            if (srst || !railEn_d[b]) begin
                cnt_q            <= '0;
                softstartBusy[b] <= 1'b0;
            end else if (start) begin
                cnt_q            <= scaled;
                softstartBusy[b] <= 1'b1;
            end else if (usTick && cnt_q != '0) begin
                cnt_q            <= cnt_q - SS_W'(1);
                softstartBusy[b] <= (cnt_q != SS_W'(1));
            end
        end
    end

    // ==========================================================
    // reset channels: 0 main, 1 aux a, 2 aux b
    logic [2:0]             bad, asserted_q;
    logic [2:0][DLY_W-1:0]  target;
    logic [NUM_RAILS-1:0]   railLow;
    logic                   auxPokA, auxPokB;
    assign railLow  = railEnable & ~railPowerOk;
    assign auxPokA  = !active || |(railLow & auxSelA);
    assign auxPokB  = !active || |(railLow & auxSelB);
    assign bad[0]   = !vinWindowOk || !active || |railLow;
    assign bad[1]   = (auxCfgA == AUX_POK)    ? auxPokA :
                      (auxCfgA == AUX_SLEEP)  ? sleepState :
                      (auxCfgA == AUX_WINDOW) ? !vinWindowOk : 1'b0;
    assign bad[2]   = (auxCfgB == AUX_POK)    ? auxPokB :
                      (auxCfgB == AUX_SLEEP)  ? sleepState :
                      (auxCfgB == AUX_WINDOW) ? !vinWindowOk : 1'b0;
    assign target[0] = MAIN_BASE_US +
                       DLY_W'(MAIN_STEP_US * ctrl_q[CTRL_MAIN_DLY +: 3]);
    assign target[1] = AUXA_BASE_US +
                       DLY_W'(AUXA_STEP_US * ctrl_q[CTRL_AUXA_DLY +: 3]);
    assign target[2] = AUXB_BASE_US +
                       DLY_W'(AUXB_STEP_US * ctrl_q[CTRL_AUXB_DLY +: 3]);

    for (genvar c = 0; c < 3; c++) begin : g_rst
        logic [DLY_W-1:0] cnt_q;
        always_ff @(posedge clk_sys) begin
            if (srst || bad[c]) begin
                asserted_q[c] <= 1'b1;
                cnt_q         <= '0;
            end else if (asserted_q[c] && usTick) begin
                if (cnt_q + DLY_W'(1) >= target[c]) asserted_q[c] <= 1'b0;
                else                                cnt_q <= cnt_q + DLY_W'(1);
            end
        end
    end

    // ==========================================================
    // pin drivers
    logic pgOk, pgMasked, extSrc;
    assign pgOk     = (pgSrc == PG_LDO2_B4) ? railPowerOk[RAIL_LDO2] & railPowerOk[RAIL_B4] :
                      (pgSrc == PG_LDO3_B4) ? railPowerOk[RAIL_LDO3] & railPowerOk[RAIL_B4] :
                      (pgSrc == 3'h6)       ? railPowerOk[RAIL_LDO3] :
                      railPowerOk[pgSrc];
    assign pgMasked = (pgSrc == PG_LDO2_B4) ? uvMask[RAIL_LDO2] | uvMask[RAIL_B4] :
                      (pgSrc == PG_LDO3_B4) ? uvMask[RAIL_LDO3] | uvMask[RAIL_B4] :
                      (pgSrc == 3'h6)       ? uvMask[RAIL_LDO3] :
                      uvMask[pgSrc];
    // bypass switch and buck1 share rail 0 enable; extSrc follows that enable for either strap value
    assign extSrc   = strap_q ? (railEn_d[0] & strap_q) : (railEn_d[0] & ~strap_q);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mainResetOut      <= 1'b0;
            mainResetOe       <= 1'b1;
            auxResetOutA      <= 1'b0;
            auxResetOeA       <= 1'b1;
            auxResetOutB      <= 1'b0;
            auxResetOeB       <= 1'b1;
            externalEnableOut <= 1'b0;
            powerGoodOut      <= 1'b0;
            powerGoodOe       <= 1'b1;
        end else begin
            mainResetOut      <= 1'b0;
            mainResetOe       <= asserted_q[0];
            auxResetOutA      <= 1'b0;
            auxResetOeA       <= asserted_q[1] && auxCfgA != AUX_INPUT;
            auxResetOutB      <= 1'b0;
            auxResetOeB       <= asserted_q[2] && auxCfgB != AUX_INPUT;
            externalEnableOut <= extSrc ^ extPol;
            powerGoodOut      <= 1'b0;
            powerGoodOe       <= !pgOk && !pgMasked;
        end
    end

    // ==========================================================
    // status word
    assign statusWord = {12'h000, softstartBusy, 1'b0, active, strap_q, externalEnableOut,
                         powerGoodOe, auxResetOeB, auxResetOeA, mainResetOe,
                         1'b0, railEnable};
endmodule : prs_reset_status

// file: test/prs_checker.sv
// Purpose: port assertions for prs_reset_status
// Assumes: TICK_CYCLES matches the bound instance
// Notes: release bounds allow two cycles of skew
`timescale 1ns/1ps
module prs_checker import prs_pkg::*; #(parameter int unsigned TICK_CYCLES = 1) (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        vinWindowOk,
    input wire logic [6:0]  railPowerOk,
    input wire logic [6:0]  railEnable,
    input wire logic [3:0]  outputDischargeOn,
    input wire logic        mainResetOut,
    input wire logic        mainResetOe,
    input wire logic        auxResetOeA,
    input wire logic        externalEnableOut
);
    // ======
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic        pol_q, inA_q;
    logic [15:0] good_q;
    logic [3:0]  calm_q;
    wire         polWr = psel && penable && pready && pwrite && paddr == OFS_CTRL;
    // disabled rails cannot hold a release back
    wire         railsOk = vinWindowOk && &(railPowerOk | ~railEnable);
    always_ff @(posedge clk_sys) begin
        pol_q <= srst ? 1'b0 : (polWr ? pwdata[CTRL_EXT_POL] : pol_q);
        inA_q <= srst ? 1'b0 : (polWr ? &pwdata[CTRL_AUXA_CFG +: 2] : inA_q);
        good_q <= railsOk ? good_q + 16'(good_q != 16'hffff) : 16'h0;
        calm_q <= (srst || polWr || $changed(railEnable[0])) ? 4'h0 : calm_q + 4'(calm_q != 4'hf);
    end
    sequence winLost; !vinWindowOk [*2]; endsequence
    a_main_fast: assert property (winLost |=> mainResetOe)
        else $error("main reset late");
    a_main_hold: assert property ($fell(mainResetOe) |-> good_q >= MAIN_BASE_US*TICK_CYCLES-2)
        else $error("main reset early");
    a_auxa_hold: assert property ($fell(auxResetOeA) && !inA_q |-> good_q >= AUXA_BASE_US*TICK_CYCLES-2)
        else $error("aux a early");
    a_ext_follow: assert property (calm_q > 4'h2 |-> externalEnableOut == (railEnable[0] ^ pol_q))
        else $error("ext enable wrong");
    a_drain_low: assert property (!mainResetOut)
        else $error("reset pin driven high");
    a_dischg_off: assert property ((outputDischargeOn & railEnable[3:0]) != 4'h0 |=>
        (outputDischargeOn & railEnable[3:0]) == 4'h0) else $error("discharge on live rail");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready early");
    a_err_pair: assert property (pslverr |-> pready)
        else $error("pslverr alone");
endmodule : prs_checker
bind prs_reset_status prs_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);

// file: test/prs_host_model.sv
// Purpose: host side: pull-ups on the two aux reset lines, rail ok feedback
// Assumes: a rail reports ok LAT+1 cycles after its enable
// Notes: railFault forces rails low to model a sagging output
`timescale 1ns/1ps
module prs_host_model #(parameter int unsigned LAT = 2) (
    input  wire logic       clk_sys,
    input  wire logic [6:0] railEnable,
    input  wire logic [6:0] railFault,
    input  wire logic       auxResetOeA,
    input  wire logic       auxResetOeB,
    output logic      [6:0] railPowerOk,
    output logic            auxLevelA,
    output logic            auxLevelB
);
    logic [3:0][6:0] pipe_q;
    always_ff @(posedge clk_sys) pipe_q <= {pipe_q[2:0], railEnable};
    assign railPowerOk = pipe_q[LAT] & railEnable & ~railFault;
    // pull-up wins unless the device sinks the line
    assign auxLevelA = !auxResetOeA;
    assign auxLevelB = !auxResetOeB;
endmodule : prs_host_model

// file: test/tb.sv
// Purpose: self-checking bench for prs_reset_status
// Assumes: one tick per clock, so a microsecond is one cycle
// Notes: timed releases accept a few cycles of skew
`timescale 1ns/1ps
module tb;
    import prs_pkg::*;
    localparam int unsigned TK = 1;
    localparam logic [4:0][31:0] DFLT = {AUXSRC_RST, UVMASK_RST, SSRAMP_RST, BUCK_RST, CTRL_RST};
    localparam logic [4:0][31:0] MSK = {AUXSRC_MASK, UVMASK_MASK, SSRAMP_MASK, BUCK_MASK, CTRL_MASK};
    logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, err, vinUvloOk, vinWindowOk;
    logic        sleepState, faultRestart, modeStrap, mainResetOut, mainResetOe, auxResetInA;
    logic        auxResetOutA, auxResetOeA, auxResetInB, auxResetOutB, auxResetOeB;
    logic        externalEnableOut, powerGoodOut, powerGoodOe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, w, ctrl, ssr;
    logic [6:0]  railPowerOk, railEnable, railFault;
    logic [3:0]  lightLoadLowPowerMode, outputDischargeOn, softstartBusy;
    int          n_mismatch = 0, cmp_count = 0, mc, ac, r;
    prs_reset_status #(.TICK_CYCLES(TK)) dut_u (.*);
    prs_host_model #(.LAT(2)) host_u (.clk_sys, .railEnable, .railFault, .auxResetOeA,
        .auxResetOeB, .railPowerOk, .auxLevelA(auxResetInA), .auxLevelB(auxResetInB));
    // ======
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk_sys) penable <= 1'b1;
        i = 0;
        do begin @(posedge clk_sys); i++; end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (i >= 50) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : apb
    // counts cycles while a pin stays high, wait for rise first if asked
    task automatic timeHigh(input int sel, input bit rise, input int exp);
        int n;
        logic [2:0] v;
        for (n = 0; n < 3000; n++) begin
            v = {softstartBusy[3], auxResetOeA, mainResetOe};
            if (v[sel] === rise) break;
            @(posedge clk_sys);
        end
        if (rise) timeHigh(sel, 1'b0, exp);
        else cmp(32'((n >= exp - 2 && n <= exp + 4) ? exp : n), 32'(exp));
    endtask : timeHigh
    function automatic int ssCyc(input int us, input int ref06);
        return (ref06 ? (us * 3 + 3) / 4 : us) * TK;
    endfunction : ssCyc
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {vinUvloOk, vinWindowOk, sleepState, faultRestart, modeStrap, railFault} = 12'h080;
        r = $urandom(83);
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            cmp(rd, DFLT[k]);
            w = $urandom();
            apb(1'b1, 8'(4 * k), w);
            apb(1'b0, 8'(4 * k), 32'h0);
            cmp(rd, w & MSK[k]);
            if (k == 2) ssr = rd;
        end
        apb(1'b0, 8'h18, 32'h0);
        cmp({rd[30:0], err}, 32'h1);
        $display("registers done");
        mc = $urandom_range(7);
        ac = $urandom_range(7);
        ctrl = 32'(mc << CTRL_MAIN_DLY | ac) | 32'h1 << CTRL_EXT_POL;
        apb(1'b1, OFS_CTRL, ctrl);
        apb(1'b1, OFS_BUCK, 32'h0);
        apb(1'b1, OFS_UVMASK, 32'h0);
        apb(1'b1, OFS_AUXSRC, AUXSRC_RST);
        {vinWindowOk, vinUvloOk} <= 2'b11;
        for (r = 0; r < 5000 && !(&railPowerOk); r++) @(posedge clk_sys);
        fork
            timeHigh(0, 1'b0, (200 + 114 * mc) * TK);
            timeHigh(1, 1'b0, (400 + 227 * ac) * TK);
        join
        modeStrap <= 1'b0;
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp(32'(rd[ST_STRAP]), 32'h1);
        cmp(32'(externalEnableOut), 32'h0);
        $display("bring-up done");
        vinWindowOk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmp(32'(mainResetOe), 32'h1);
        vinWindowOk <= 1'b1;
        repeat (60) @(posedge clk_sys);
        vinWindowOk <= 1'b0;
        repeat (2) @(posedge clk_sys);
        vinWindowOk <= 1'b1;
        timeHigh(0, 1'b0, (200 + 114 * mc) * TK);
        $display("fault recovery done");
        r = $urandom_range(1);
        apb(1'b1, OFS_BUCK, 32'(r) << 19 | 32'ha358);
        repeat (4) @(posedge clk_sys);
        cmp(32'(lightLoadLowPowerMode), 32'h2);
        cmp(32'(railEnable[3]), 32'h0);
        cmp(32'(outputDischargeOn), 32'h8);
        apb(1'b1, OFS_BUCK, 32'(r) << 19);
        timeHigh(2, 1'b1, ssCyc(SS_B4_US[ssr[14:12]], r));
        faultRestart <= 1'b1;
        @(posedge clk_sys) faultRestart <= 1'b0;
        timeHigh(2, 1'b1, ssCyc(SS_B4_US[ssr[14:12]], r));
        $display("bucks done");
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, OFS_CTRL, ctrl | 32'(s) << CTRL_PG_SRC);
            apb(1'b1, OFS_UVMASK, 32'h0);
            railFault <= 7'h1 << (s == 7 ? 6 : s);
            repeat (4) @(posedge clk_sys);
            cmp(32'(powerGoodOe), 32'h1);
            apb(1'b1, OFS_UVMASK, 32'h1 << (s == 7 ? 6 : s));
            repeat (3) @(posedge clk_sys);
            cmp(32'(powerGoodOe), 32'h0);
            railFault <= 7'h0;
        end
        $display("power good done");
        give_verdict();
    end
endmodule : tb
